// File: rtl/ftd_defs.vh
// Constants for the flow-unit and temperature decoder
`ifndef FTD_DEFS_VH
`define FTD_DEFS_VH
`define FTD_WORD_W        16
`define FTD_PFX_LSB       0
`define FTD_PFX_MSB       3
`define FTD_TB_LSB        4
`define FTD_TB_MSB        7
`define FTD_UNIT_LSB      8
`define FTD_UNIT_MSB      12
`define FTD_PFX_MIN       4'h3
`define FTD_PFX_MAX       4'hd
`define FTD_PFX_ONE       4'h8
`define FTD_TB_MAX        4'h6
`define FTD_UNIT_NORM0    5'h00
`define FTD_UNIT_STD25    5'h03
`define FTD_UNIT_LITER    5'h08
`define FTD_UNIT_GRAM     5'h09
`define FTD_TEMP_SCALE    16'h00c8
`define FTD_TEMP_OFFSET   16'h0000
`define FTD_FRAC_W        8
`define FTD_DIV_CYCLES    5'h18
`endif

// File: rtl/ftd_unit_field.v
// Range check of one unit-word field against an allowed code window
`timescale 1ns/10ps
module ftd_unit_field #(
  parameter W = 4
) (
  input  wire [W-1:0] code,
  input  wire [W-1:0] lo,
  input  wire [W-1:0] hi,
  output wire         ok
);
  assign ok = (code >= lo) && (code <= hi);
endmodule

// File: rtl/ftd_decoder.v
// Temperature conversion and flow-unit word splitting
`timescale 1ns/10ps
`include "ftd_defs.vh"
// Notes on behaviour
// [RULE_01] Temperature word is 16-bit signed two's complement
// [RULE_02] Celsius equals raw minus offset, over scale
// [RULE_03] Unit word: low 13 bits carry fields
// [RULE_04] Bits 3:0 prefix, codes 3..13, 8 is one
// [RULE_05] Bits 7:4 time base, codes 0..6
// [RULE_06] Bits 12:8 unit: 0..3, 8, 9
// [RULE_07] Flag bad codes, ignore bits 15..13
module ftd_decoder (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        temp_valid,
  input  wire [15:0] temp_raw,
  input  wire        unit_valid,
  input  wire [15:0] unit_raw,
  output reg         temp_busy_q,
  output reg         temp_done_q,
  output reg  [15:0] temp_int_q,
  output reg  [7:0]  temp_frac_q,
  output reg         unit_done_q,
  output reg  [3:0]  unit_prefix_q,
  output reg  [3:0]  unit_timebase_q,
  output reg  [4:0]  unit_kind_q,
  output reg         unit_is_one_q,
  output reg         unit_invalid_q
);
  ////////////////////////////////////////////////////////////////////////////
  // Temperature: remove the offset, then divide by the scale one bit a cycle
  localparam ST_IDLE = 2'b01;
  localparam ST_DIV  = 2'b10;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [4:0]  cnt_q;
  reg  [4:0]  cnt_d;
  reg         neg_q;
  reg         neg_d;
  reg  [23:0] quo_q;
  reg  [23:0] quo_d;
  reg  [16:0] rem_q;
  reg  [16:0] rem_d;
  reg         temp_busy_d;
  reg         temp_done_d;
  reg  [15:0] temp_int_d;
  reg  [7:0]  temp_frac_d;
  wire [15:0] offset;
  wire [15:0] scale;
  wire [16:0] diff;
  wire [16:0] mag;
  wire [16:0] rem_sh;
  wire        take;
  wire [23:0] quo_n;
  wire [23:0] res;

  assign offset = `FTD_TEMP_OFFSET;
  assign scale  = `FTD_TEMP_SCALE;
  // Sign-extend before subtracting so the full -32768..32767 range survives
  assign diff   = {temp_raw[15], temp_raw} - {offset[15], offset}; // [RULE_01]
  assign mag    = diff[16] ? (17'h00000 - diff) : diff;
  // Serial restoring divide: one quotient bit a cycle keeps area small
  assign rem_sh = {rem_q[15:0], quo_q[23]};
  assign take   = rem_sh >= {1'b0, scale};
  assign quo_n  = {quo_q[22:0], take};
  // Fixed point with 8 fraction bits; sign goes on last, so it truncates toward zero
  assign res    = neg_q ? (24'h000000 - quo_n) : quo_n;

  always @* begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    neg_d       = neg_q;
    quo_d       = quo_q;
    rem_d       = rem_q;
    temp_busy_d = temp_busy_q;
    temp_done_d = 1'b0;
    temp_int_d  = temp_int_q;
    temp_frac_d = temp_frac_q;
    case (state_q)
      ST_IDLE: begin
        if (temp_valid) begin
          neg_d       = diff[16]; // [RULE_02]
          // Offset zero keeps the magnitude within 16 bits, so bit 16 can go
          quo_d       = {mag[15:0], 8'h00};
          rem_d       = 17'h00000;
          cnt_d       = `FTD_DIV_CYCLES;
          temp_busy_d = 1'b1;
          state_d     = ST_DIV;
        end
      end
      ST_DIV: begin
        // A request that arrives now is dropped with no sign to the host
        rem_d = take ? (rem_sh - {1'b0, scale}) : rem_sh; // [RULE_02]
        quo_d = quo_n;
        cnt_d = cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          temp_int_d  = res[23:8];
          temp_frac_d = res[7:0];
          temp_done_d = 1'b1;
          temp_busy_d = 1'b0;
          state_d     = ST_IDLE;
        end
      end
      default: begin
        state_d     = ST_IDLE;
        temp_busy_d = 1'b0;
      end
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      state_q     <= ST_IDLE;
      cnt_q       <= 5'h00;
      neg_q       <= 1'b0;
      quo_q       <= 24'h000000;
      rem_q       <= 17'h00000;
      temp_busy_q <= 1'b0;
      temp_done_q <= 1'b0;
      temp_int_q  <= 16'h0000;
      temp_frac_q <= 8'h00;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      neg_q       <= neg_d;
      quo_q       <= quo_d;
      rem_q       <= rem_d;
      temp_busy_q <= temp_busy_d;
      temp_done_q <= temp_done_d;
      temp_int_q  <= temp_int_d;
      temp_frac_q <= temp_frac_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flow-unit word: split into its three fields and range-check each
  wire [3:0] pfx;
  wire [3:0] tb;
  wire [4:0] kind;
  wire       pfx_ok;
  wire       tb_ok;
  wire       std_ok;
  wire       lg_ok;
  wire       kind_ok;
  reg        unit_done_d;
  reg  [3:0] unit_prefix_d;
  reg  [3:0] unit_timebase_d;
  reg  [4:0] unit_kind_d;
  reg        unit_is_one_d;
  reg        unit_invalid_d;

  // Bits 15..13 are never looked at, so junk there cannot flag a word
  assign pfx  = unit_raw[`FTD_PFX_MSB:`FTD_PFX_LSB];    // [RULE_04]
  assign tb   = unit_raw[`FTD_TB_MSB:`FTD_TB_LSB];      // [RULE_05]
  assign kind = unit_raw[`FTD_UNIT_MSB:`FTD_UNIT_LSB];  // [RULE_06]

  ftd_unit_field #(.W(4)) u_pfx (
    .code (pfx),
    .lo   (`FTD_PFX_MIN),
    .hi   (`FTD_PFX_MAX),
    .ok   (pfx_ok)
  );

  ftd_unit_field #(.W(4)) u_tb (
    .code (tb),
    .lo   (4'h0),
    .hi   (`FTD_TB_MAX),
    .ok   (tb_ok)
  );

  ftd_unit_field #(.W(5)) u_std (
    .code (kind),
    .lo   (`FTD_UNIT_NORM0),
    .hi   (`FTD_UNIT_STD25),
    .ok   (std_ok)
  );

  // Liter and gram sit apart from the four gas-volume codes
  ftd_unit_field #(.W(5)) u_lg (
    .code (kind),
    .lo   (`FTD_UNIT_LITER),
    .hi   (`FTD_UNIT_GRAM),
    .ok   (lg_ok)
  );
  assign kind_ok = std_ok || lg_ok; // [RULE_06]

  always @* begin
    unit_done_d     = unit_valid;
    unit_prefix_d   = unit_prefix_q;
    unit_timebase_d = unit_timebase_q;
    unit_kind_d     = unit_kind_q;
    unit_is_one_d   = unit_is_one_q;
    unit_invalid_d  = unit_invalid_q;
    // Fields hold between words so a slow reader still sees them
    if (unit_valid) begin
      unit_prefix_d   = pfx;                            // [RULE_03]
      unit_timebase_d = tb;                             // [RULE_03]
      unit_kind_d     = kind;                           // [RULE_03]
      unit_is_one_d   = (pfx == `FTD_PFX_ONE);          // [RULE_04]
      unit_invalid_d  = !(pfx_ok && tb_ok && kind_ok);  // [RULE_07]
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      unit_done_q     <= 1'b0;
      unit_prefix_q   <= 4'h0;
      unit_timebase_q <= 4'h0;
      unit_kind_q     <= 5'h00;
      unit_is_one_q   <= 1'b0;
      unit_invalid_q  <= 1'b0;
    end else begin
      unit_done_q     <= unit_done_d;
      unit_prefix_q   <= unit_prefix_d;
      unit_timebase_q <= unit_timebase_d;
      unit_kind_q     <= unit_kind_d;
      unit_is_one_q   <= unit_is_one_d;
      unit_invalid_q  <= unit_invalid_d;
    end
  end
endmodule

// File: tb/ftd_checker.sv
// Port-level assertions for the decoder
`timescale 1ns/10ps
module ftd_checker (
  input wire        clock,
  input wire        sys_rst,
  input wire        temp_valid,
  input wire [15:0] temp_raw,
  input wire        unit_valid,
  input wire [15:0] unit_raw,
  input wire        temp_busy_q,
  input wire        temp_done_q,
  input wire [15:0] temp_int_q,
  input wire [7:0]  temp_frac_q,
  input wire        unit_done_q,
  input wire [3:0]  unit_prefix_q,
  input wire [3:0]  unit_timebase_q,
  input wire [4:0]  unit_kind_q,
  input wire        unit_is_one_q,
  input wire        unit_invalid_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_take; temp_valid && !temp_busy_q; endsequence
  sequence s_div; temp_busy_q [*8]; endsequence
  property p_tdone; s_take |=> s_div ##17 temp_done_q; endproperty
  a_tdone: assert property (p_tdone) else $error("conversion latency wrong");
  property p_tbusy; temp_done_q |-> !temp_busy_q; endproperty
  a_tbusy: assert property (p_tbusy) else $error("busy during done");
  property p_udone; unit_valid |=> unit_done_q; endproperty
  a_udone: assert property (p_udone) else $error("unit done missing");
  property p_pfx; unit_valid |=> unit_prefix_q == $past(unit_raw[3:0]); endproperty
  a_pfx: assert property (p_pfx) else $error("prefix field wrong");
  property p_tb; unit_valid |=> unit_timebase_q == $past(unit_raw[7:4]); endproperty
  a_tb: assert property (p_tb) else $error("time base field wrong");
  property p_kind; unit_valid |=> unit_kind_q == $past(unit_raw[12:8]); endproperty
  a_kind: assert property (p_kind) else $error("unit field wrong");
  property p_one; unit_done_q |-> unit_is_one_q == (unit_prefix_q == 4'h8); endproperty
  a_one: assert property (p_one) else $error("unity flag wrong");
  property p_inv;
    unit_done_q |-> unit_invalid_q == (unit_prefix_q < 4'h3 || unit_prefix_q > 4'hd ||
      unit_timebase_q > 4'h6 || (unit_kind_q > 5'h03 && unit_kind_q != 5'h08 &&
      unit_kind_q != 5'h09));
  endproperty
  a_inv: assert property (p_inv) else $error("invalid flag wrong");
endmodule
bind ftd_decoder ftd_checker ftd_checker_inst (.*);

// File: tb/ftd_host_model.sv
// Host side that hands sensor words to the decoder
`timescale 1ns/10ps
module ftd_host_model (
  input  wire        clock,
  output reg         temp_valid,
  output reg  [15:0] temp_raw,
  output reg         unit_valid,
  output reg  [15:0] unit_raw
);
  initial {temp_valid, temp_raw, unit_valid, unit_raw} = 34'h0;
  // One-cycle pulses; data changes only on the falling edge
  task req_temp(input [15:0] r);
    @(negedge clock) {temp_valid, temp_raw} = {1'b1, r};
    @(negedge clock) temp_valid = 1'b0;
  endtask
  task req_unit(input [15:0] w);
    @(negedge clock) {unit_valid, unit_raw} = {1'b1, w};
    @(negedge clock) {unit_valid, unit_raw} = {1'b0, ~w};
  endtask
endmodule

// File: tb/tb_flow_unit_and_temp_decoder.sv
// Self-checking bench for the decoder
`timescale 1ns/10ps
`define CHK(a, b) begin \
  n_tests++; \
  if ((a) !== (b)) begin \
    errors++; \
    $display("unexpected t=%0t got %h exp %h", $time, (a), (b)); \
  end \
end
module tb_flow_unit_and_temp_decoder;
  reg clock = 1'b0;
  reg sys_rst = 1'b1;
  int errors = 0;
  int n_tests = 0;
  wire tv, uv, busy, tdone, udone, one, inv;
  wire [15:0] tr, ur, ti;
  wire [7:0] tf;
  wire [3:0] pf, tb;
  wire [4:0] kd;
  initial forever #4 clock = ~clock;
  ftd_host_model ftd_host_model_inst (.clock(clock), .temp_valid(tv), .temp_raw(tr),
    .unit_valid(uv), .unit_raw(ur));
  ftd_decoder ftd_decoder_inst (.clock(clock), .sys_rst(sys_rst), .temp_valid(tv),
    .temp_raw(tr), .unit_valid(uv), .unit_raw(ur), .temp_busy_q(busy), .temp_done_q(tdone),
    .temp_int_q(ti), .temp_frac_q(tf), .unit_done_q(udone), .unit_prefix_q(pf),
    .unit_timebase_q(tb), .unit_kind_q(kd), .unit_is_one_q(one), .unit_invalid_q(inv));
  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Second request lands while busy and must be dropped
  task t_temp(input [15:0] r);
    int e;
    int n;
    e = ($signed(r) * 32'sh100) / 32'sh0c8;
    ftd_host_model_inst.req_temp(r);
    ftd_host_model_inst.req_temp(~r);
    `CHK(busy, 1'b1)
    n = 0;
    while (n < 40 && tdone !== 1'b1) begin
      @(negedge clock);
      n++;
    end
    // Done shows after the 24th edge past the taking one; the requests used two
    `CHK(n, 32'h16)
    `CHK({tdone, busy}, 2'b10)
    `CHK({ti, tf}, e[23:0])
    $display("temp test %h done", r);
  endtask
  // Every prefix and unit code and time-base codes 0..7, with the ignored top bits set
  task t_unit;
    logic [15:0] w;
    logic        bad;
    for (int i = 0; i < 32; i++) begin
      w = {3'h7, i[4:0], 1'b0, i[2:0], i[3:0]};
      bad = w[3:0] < 4'h3 || w[3:0] > 4'hd || w[7:4] > 4'h6;
      bad = bad || !(w[12:8] < 5'h04 || w[12:8] == 5'h08 || w[12:8] == 5'h09);
      ftd_host_model_inst.req_unit(w);
      `CHK({udone, pf, tb, kd, one}, {1'b1, w[3:0], w[7:4], w[12:8], w[3:0] == 4'h8})
      `CHK(inv, bad)
    end
    $display("unit test done");
  endtask
  // Reset in mid-conversion clears every output at once
  task t_reset;
    ftd_host_model_inst.req_unit(16'h0148);
    ftd_host_model_inst.req_temp(16'h00c8);
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    `CHK({busy, tdone, ti, tf}, 26'h0000000)
    `CHK({udone, pf, tb, kd, one, inv}, 16'h0000)
    sys_rst = 1'b0;
    $display("reset test done");
  endtask
  initial begin
    #40000 errors++;
    complete_run;
  end
  initial begin
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    t_unit;
    t_temp(16'h8000);
    t_temp(16'h7fff);
    t_temp(16'hfe0b);
    t_reset;
    t_temp(16'h00c8);
    complete_run;
  end
endmodule
